// File: logic/oat_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 20 mhz clock and byte addressing on the register bus
`ifndef OAT_REGS_SVH
`define OAT_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OAT_OFF_CTRL 4'h0
`define OAT_OFF_LAT 4'h4
`define OAT_OFF_TIMING 4'h8
`define OAT_OFF_STATUS 4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define OAT_CTRL_DLL_ON_BIT 0
`define OAT_LAT_CWL_LSB 0
`define OAT_LAT_ADD_LSB 8
`define OAT_TIM_CPDED_LSB 0
`define OAT_TIM_XPDLL_LSB 8
`define OAT_TIM_RFC_LSB 16
`define OAT_ST_TERM_BIT 0
`define OAT_ST_MODE_LSB 1
`define OAT_ST_PD_BIT 3
`define OAT_ST_ASYNC_BIT 4
`define OAT_ST_WIN_LSB 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define OAT_RST_DLL_ON 1'b0
`define OAT_RST_CWL 5'h05
`define OAT_RST_ADD 5'h00
`define OAT_RST_CPDED 8'h01
`define OAT_RST_XPDLL 8'h0a
`define OAT_RST_RFC 8'h05

// ----------------------------------------
// timing
// ----------------------------------------
`define OAT_CLK_PS 50000
`define OAT_ASYNC_MIN_PS 2000
`define OAT_ASYNC_MAX_PS 8500
`define OAT_ASYNC_MIN_CYC ((`OAT_ASYNC_MIN_PS + `OAT_CLK_PS - 1) / `OAT_CLK_PS)
`define OAT_ASYNC_MAX_RAW (`OAT_ASYNC_MAX_PS / `OAT_CLK_PS)
`define OAT_ASYNC_MAX_CYC ((`OAT_ASYNC_MAX_RAW < 1) ? 1 : `OAT_ASYNC_MAX_RAW)
`define OAT_SYNC_LAT_OFFSET 2
`define OAT_ANPD_OFFSET 1

`endif

// File: logic/oat_pkg.sv
// types shared by the termination control files
// assumes the constants header is included where numbers are needed
package oat_pkg;

    typedef enum logic [1:0] {
        OAT_MODE_SYNC = 2'b00,
        OAT_MODE_ASYNC = 2'b01,
        OAT_MODE_UNDET = 2'b10
    } oat_mode_e;

    typedef struct packed {
        logic cke;
        logic odt;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } oat_pins_s;

endpackage

// File: logic/oat_delay_line.sv
// tapped delay line for the synchronous termination path
// assumes the tap index is stable and below DEPTH
`timescale 1ns/1ns
module oat_delay_line #(
    parameter int DEPTH = 32,
    parameter int IDX_W = 5
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic d,
    input wire logic [IDX_W-1:0] tap,
    output logic q
);
    logic [DEPTH-2:0] line_reg;
    logic [DEPTH-1:0] taps;

    // ----------------------------------------
    // shift
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            line_reg <= '0;
        end else begin
            line_reg <= {line_reg[DEPTH-3:0], d};
        end
    end

    // tap 0 is the input itself, so a registered consumer sees one cycle
    assign taps = {line_reg, d};
    assign q = taps[tap];

endmodule

// File: logic/oat_term_ctrl.sv
// termination control with power-down sync/async mode transitions
// assumes pins arrive from another domain and an avalon-mm master
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "oat_regs.svh"

// Operation
// R1: frozen dll power-down selects async termination
// R2: async path skips additive latency
// R3: async turn-on between 2 and 8.5 ns
// R4: async turn-off between 2 and 8.5 ns
// R5: termination pin receiver stays active in power-down
// R6: controller issues no read/write in power-down
// R7: bit zero gives transition period, either response
// R8: entry period ends after command pass-through time
// R9: pending refresh extends entry period end
// R10: start cycle excluded, end cycles included
// R11: turn-on within sync/async bounds in window
// R12: turn-off within sync/async bounds in window
// R13: exit period ends after exit-to-locked delay
// R14: overlapping entry/exit spans to exit end
// R15: overlapping exit/entry spans to entry end
// R16: controller holds termination pin high 4 clocks
// R17: sync turn-on write_latency minus two clocks
// R18: sync turn-off write_latency minus two clocks
// R19: counters track windows, flag the timing mode
module oat_term_ctrl
    import oat_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int IDX_W = 5
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cke,
    input wire logic odt,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    output logic term_on,
    output logic [1:0] term_mode,
    output logic in_power_down,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    oat_pins_s pins_in;
    oat_pins_s meta_reg;
    oat_pins_s pins_reg;
    logic cke_prev_reg;
    logic dll_on_reg;
    logic [4:0] cwl_reg;
    logic [4:0] additive_latency_reg;
    logic [7:0] cpded_reg;
    logic [7:0] xpdll_reg;
    logic [7:0] rfc_reg;
    logic [7:0] rfc_cnt_reg;
    logic [7:0] win_cnt_reg;
    logic [7:0] entry_len;
    logic [7:0] win_next;
    logic pd_reg;
    logic async_reg;
    logic term_reg;
    oat_mode_e mode_reg;
    oat_mode_e mode_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [5:0] write_latency;
    logic [5:0] sync_term_on_latency;
    logic [IDX_W-1:0] sync_tap;
    logic sync_q;
    logic cke_fall;
    logic cke_rise;
    logic refresh_cmd;
    logic async_next;
    logic wr_hit;

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    assign pins_in = '{cke: cke, odt: odt, cs_n: cs_n, ras_n: ras_n,
                       cas_n: cas_n, we_n: we_n};

    // R5: odt sampled always
    always_ff @(posedge clock) begin
        if (!rstn) begin
            meta_reg <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                          we_n: 1'b1, odt: 1'b0};
            pins_reg <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                          we_n: 1'b1, odt: 1'b0};
        end else begin
            meta_reg <= pins_in;
            pins_reg <= meta_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cke_prev_reg <= 1'b1;
        end else begin
            cke_prev_reg <= pins_reg.cke;
        end
    end

    // ----------------------------------------
    // edge and command decode
    // ----------------------------------------
    assign cke_fall = cke_prev_reg & ~pins_reg.cke;
    assign cke_rise = ~cke_prev_reg & pins_reg.cke;

    // R6: no decode while cke is low
    assign refresh_cmd = cke_prev_reg & pins_reg.cke & ~pins_reg.cs_n &
                         ~pins_reg.ras_n & ~pins_reg.cas_n & pins_reg.we_n;

    // ----------------------------------------
    // latencies
    // ----------------------------------------
    assign write_latency = {1'b0, cwl_reg} + {1'b0, additive_latency_reg};

    // R17: on latency is write_latency minus two
    // R18: off latency equals the on latency
    assign sync_term_on_latency = (write_latency > 6'(`OAT_SYNC_LAT_OFFSET + 1)) ?
        6'(write_latency - 6'(`OAT_SYNC_LAT_OFFSET)) : 6'h01;

    // tap 0 plus the output flop gives one cycle of delay
    assign sync_tap = IDX_W'(sync_term_on_latency - 6'h01);

    oat_delay_line #(
        .DEPTH(DEPTH),
        .IDX_W(IDX_W)
    ) u_sync_line (
        .clock(clock),
        .rstn(rstn),
        .d(pins_reg.odt),
        .tap(sync_tap),
        .q(sync_q)
    );

    // ----------------------------------------
    // power-down and async mode
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pd_reg <= 1'b0;
        end else if (cke_fall) begin
            pd_reg <= 1'b1;
        end else if (cke_rise) begin
            pd_reg <= 1'b0;
        end
    end

    // R1: frozen dll in power-down
    assign async_next = ~dll_on_reg & (pd_reg | cke_fall) & ~cke_rise;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            async_reg <= 1'b0;
        end else begin
            async_reg <= async_next;
        end
    end

    // ----------------------------------------
    // termination output
    // ----------------------------------------
    // switching paths at once is legal: a change older than the
    // write_latency-3 lookback has already reached the sync tap
    always_ff @(posedge clock) begin
        if (!rstn) begin
            term_reg <= 1'b0;
        end else if (async_next) begin
            // R2: pin used directly
            // R3: one cycle turn-on
            // R4: one cycle turn-off
            term_reg <= pins_reg.odt;
        end else begin
            // R11: either path in window
            // R12: same for turn-off
            term_reg <= sync_q;
        end
    end

    // ----------------------------------------
    // refresh tracking
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rfc_cnt_reg <= 8'h00;
        end else if (refresh_cmd) begin
            rfc_cnt_reg <= rfc_reg;
        end else if (rfc_cnt_reg != 8'h00) begin
            rfc_cnt_reg <= rfc_cnt_reg - 8'h01;
        end
    end

    // ----------------------------------------
    // transition windows
    // ----------------------------------------
    // R9: later of refresh and pass-through
    assign entry_len = (rfc_cnt_reg > cpded_reg) ? rfc_cnt_reg : cpded_reg;

    // the lookback part before the cke edge cannot be flagged live;
    // only the part from the edge onward shows in the counter
    always_comb begin
        win_next = (win_cnt_reg != 8'h00) ? win_cnt_reg - 8'h01 : 8'h00;
        if (dll_on_reg) begin
            win_next = 8'h00;
        end else if (cke_fall) begin
            // R8: entry period from cke low
            // R15: keep the longer remainder
            win_next = (entry_len > win_next) ? entry_len : win_next;
        end else if (cke_rise) begin
            // R13: exit period from cke high
            // R14: keep the longer remainder
            win_next = (xpdll_reg > win_next) ? xpdll_reg : win_next;
        end
    end

    // R19: window counter
    always_ff @(posedge clock) begin
        if (!rstn) begin
            win_cnt_reg <= 8'h00;
        end else begin
            win_cnt_reg <= win_next;
        end
    end

    // R7: undetermined only with frozen dll
    // R10: edge cycle through last count
    always_comb begin
        if (win_next != 8'h00) begin
            mode_next = OAT_MODE_UNDET;
        end else if (async_next) begin
            mode_next = OAT_MODE_ASYNC;
        end else begin
            mode_next = OAT_MODE_SYNC;
        end
    end

    // R19: mode flag
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode_reg <= OAT_MODE_SYNC;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ----------------------------------------
    // avalon-mm slave
    // ----------------------------------------
    // fixed one wait state keeps read data a plain flop
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    assign wr_hit = avs_write & ack_reg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dll_on_reg <= `OAT_RST_DLL_ON;
        end else if (wr_hit && avs_address == `OAT_OFF_CTRL && avs_byteenable[0]) begin
            dll_on_reg <= avs_writedata[`OAT_CTRL_DLL_ON_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cwl_reg <= `OAT_RST_CWL;
            additive_latency_reg <= `OAT_RST_ADD;
        end else if (wr_hit && avs_address == `OAT_OFF_LAT) begin
            if (avs_byteenable[0]) begin
                cwl_reg <= avs_writedata[`OAT_LAT_CWL_LSB +: 5];
            end
            if (avs_byteenable[1]) begin
                additive_latency_reg <= avs_writedata[`OAT_LAT_ADD_LSB +: 5];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cpded_reg <= `OAT_RST_CPDED;
            xpdll_reg <= `OAT_RST_XPDLL;
            rfc_reg <= `OAT_RST_RFC;
        end else if (wr_hit && avs_address == `OAT_OFF_TIMING) begin
            if (avs_byteenable[0]) begin
                cpded_reg <= avs_writedata[`OAT_TIM_CPDED_LSB +: 8];
            end
            if (avs_byteenable[1]) begin
                xpdll_reg <= avs_writedata[`OAT_TIM_XPDLL_LSB +: 8];
            end
            if (avs_byteenable[2]) begin
                rfc_reg <= avs_writedata[`OAT_TIM_RFC_LSB +: 8];
            end
        end
    end

    always_comb begin
        rdata_next = 32'h00000000;
        if (avs_address == `OAT_OFF_CTRL) begin
            rdata_next[`OAT_CTRL_DLL_ON_BIT] = dll_on_reg;
        end else if (avs_address == `OAT_OFF_LAT) begin
            rdata_next[`OAT_LAT_CWL_LSB +: 5] = cwl_reg;
            rdata_next[`OAT_LAT_ADD_LSB +: 5] = additive_latency_reg;
        end else if (avs_address == `OAT_OFF_TIMING) begin
            rdata_next[`OAT_TIM_CPDED_LSB +: 8] = cpded_reg;
            rdata_next[`OAT_TIM_XPDLL_LSB +: 8] = xpdll_reg;
            rdata_next[`OAT_TIM_RFC_LSB +: 8] = rfc_reg;
        end else if (avs_address == `OAT_OFF_STATUS) begin
            rdata_next[`OAT_ST_TERM_BIT] = term_reg;
            rdata_next[`OAT_ST_MODE_LSB +: 2] = mode_reg;
            rdata_next[`OAT_ST_PD_BIT] = pd_reg;
            rdata_next[`OAT_ST_ASYNC_BIT] = async_reg;
            rdata_next[`OAT_ST_WIN_LSB +: 8] = win_cnt_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_reg <= 32'h00000000;
        end else if (avs_read && !ack_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign term_on = term_reg;
    assign term_mode = mode_reg;
    assign in_power_down = pd_reg;
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = ~ack_reg;

endmodule

// File: verif/oat_term_ctrl_asserts.sv
// port checker for the termination control block
// assumes a bind onto oat_term_ctrl and a single clock domain
`timescale 1ns/1ns
module oat_term_ctrl_asserts
    import oat_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic cke,
    input wire logic odt,
    input wire logic term_on,
    input wire logic [1:0] term_mode,
    input wire logic in_power_down,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest
);
    // ----------------------------------------
    // shadow of the frozen-loop select
    // ----------------------------------------
    // ports alone do not show it, so follow the bus
    logic dll_q;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            dll_q <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]) begin
            dll_q <= avs_writedata[0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_async_on;
        $rose(odt) && term_mode == OAT_MODE_ASYNC |-> ##[2:4] term_on;
    endproperty
    a_async_on: assert property (p_async_on) else $error("async turn-on missed");
    property p_async_off;
        $fell(odt) && term_mode == OAT_MODE_ASYNC |-> ##[2:4] !term_on;
    endproperty
    a_async_off: assert property (p_async_off) else $error("async turn-off missed");
    property p_pd_entry;
        $fell(cke) |-> ##[2:4] in_power_down;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down not flagged");
    property p_mode_pd;
        term_mode == OAT_MODE_ASYNC |-> in_power_down;
    endproperty
    a_mode_pd: assert property (p_mode_pd) else $error("async outside power-down");
    property p_dll_sync;
        dll_q [*3] |-> term_mode == OAT_MODE_SYNC;
    endproperty
    a_dll_sync: assert property (p_dll_sync) else $error("mode not sync with loop running");
    property p_entry_win;
        $fell(cke) && !dll_q |-> ##[2:4] term_mode == OAT_MODE_UNDET;
    endproperty
    a_entry_win: assert property (p_entry_win) else $error("entry window missing");
    property p_exit_win;
        $rose(cke) && !dll_q |-> ##[2:4] term_mode == OAT_MODE_UNDET;
    endproperty
    a_exit_win: assert property (p_exit_win) else $error("exit window missing");
    property p_bus_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus ack not after one wait");
    c_async: cover property (term_mode == OAT_MODE_ASYNC && term_on);
    c_undet: cover property (term_mode == OAT_MODE_UNDET && !in_power_down);
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule

bind oat_term_ctrl oat_term_ctrl_asserts i_chk (.clock, .rstn, .cke, .odt, .term_on, .term_mode,
    .in_power_down, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest);

// File: verif/oat_ctrl_model.sv
// memory controller model driving the pin bundle
// assumes its tasks are called at rising clock edges
`timescale 1ns/1ns
module oat_ctrl_model
    import oat_pkg::*;
(
    input wire logic clock,
    output oat_pins_s pins
);
    // commands start deselected; only refresh selects them, no read or write
    initial pins = '{cke: 1'b1, odt: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
    // refresh only issued while cke is high
    task automatic refresh();
        @(posedge clock);
        pins.cs_n <= 1'b0;
        pins.ras_n <= 1'b0;
        pins.cas_n <= 1'b0;
        @(posedge clock);
        pins.cs_n <= 1'b1;
        pins.ras_n <= 1'b1;
        pins.cas_n <= 1'b1;
    endtask
    task automatic set_cke(input logic v);
        @(posedge clock);
        pins.cke <= v;
    endtask
    // enable held four clocks at least
    task automatic odt_pulse(input int hold);
        @(posedge clock);
        pins.odt <= 1'b1;
        repeat ((hold < 4) ? 4 : hold) @(posedge clock);
        pins.odt <= 1'b0;
    endtask
endmodule

// File: verif/odt_async_mode_transitions_tb_top.sv
// self-checking bench for the termination control block
// assumes package, design, checker and controller model compile first
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module odt_async_mode_transitions_tb_top;
    import oat_pkg::*;
    typedef struct {int cyc; logic [3:0] v;} oat_ev_s;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    oat_pins_s pins;
    logic term_on, in_power_down, avs_waitrequest;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [1:0] term_mode;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [3:0] res_prev = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rexp;
    logic [7:0] seed = 8'h4f;
    int cyc = 0;
    int error_cnt = 0;
    int total_checks = 0;
    oat_ev_s e;
    oat_ev_s ev_q[$];
    logic [31:0] rd_q[$];
    logic [3:0] ra[5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
    logic [31:0] rv[5] = '{32'h0, 32'h5, 32'h00050a01, 32'h0, 32'h0};
    initial forever #25 clock = ~clock;
    oat_ctrl_model i_ctrl (.clock(clock), .pins(pins));
    oat_term_ctrl i_dut (.clock, .rstn, .cke(pins.cke), .odt(pins.odt), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .term_on, .term_mode, .in_power_down, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] v);
        rd_q.push_back(v);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    // expected output vector, counted from the next drive edge
    task automatic ev(input int dt, input logic [3:0] v);
        ev_q.push_back('{cyc + 1 + dt, v});
    endtask
    task automatic pulse(input int lat, input logic [2:0] base);
        int h;
        seed = lfsr(seed);
        h = 4 + seed[1:0];
        ev(lat, {1'b1, base});
        ev(h + lat, {1'b0, base});
        i_ctrl.odt_pulse(h);
        repeat (lat + 4) @(posedge clock);
    endtask
    task automatic final_report();
        if (ev_q.size() != 0) error_cnt++;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // output monitor
    // ----------------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (rstn && {term_on, term_mode, in_power_down} !== res_prev) begin
            e = (ev_q.size() != 0) ? ev_q.pop_front() : '{-1, 4'hx};
            `CHK(cyc, e.cyc)
            `CHK({term_on, term_mode, in_power_down}, e.v)
        end
        res_prev <= {term_on, term_mode, in_power_down};
        if (avs_read && avs_waitrequest === 1'b0) begin
            rexp = rd_q.pop_front();
            `CHK(avs_readdata, rexp)
        end
    end
    always @(posedge clock) if (cyc == 3000) begin error_cnt++; final_report(); end
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        seed = lfsr(seed);
        bus(1'b1, 4'h2, {4{seed}}, 4'hf);
        bus(1'b1, 4'hc, {4{seed}}, 4'hf);
        for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
        pulse(6, 3'b000);
        bus(1'b1, 4'h4, 32'h00001f07, 4'h1);
        rd(4'h4, 32'h7);
        bus(1'b1, 4'h4, 32'h00000303, 4'hf);
        rd(4'h4, 32'h303);
        pulse(7, 3'b000);
        ev(4, 4'b0101);
        ev(5, 4'b0011);
        i_ctrl.set_cke(1'b0);
        repeat (8) @(posedge clock);
        rd(4'hc, 32'h1a);
        pulse(4, 3'b011);
        ev(4, 4'b0100);
        ev(14, 4'b0000);
        i_ctrl.set_cke(1'b1);
        repeat (16) @(posedge clock);
        // short power-down: entry and exit windows merge
        bus(1'b1, 4'h8, 32'h00050a06, 4'hf);
        ev(4, 4'b0101);
        ev(7, 4'b0100);
        ev(17, 4'b0000);
        i_ctrl.set_cke(1'b0);
        repeat (2) @(posedge clock);
        i_ctrl.set_cke(1'b1);
        repeat (20) @(posedge clock);
        // refresh in progress stretches the entry window
        bus(1'b1, 4'h8, 32'h00140a02, 4'hf);
        i_ctrl.refresh();
        ev(4, 4'b0101);
        ev(23, 4'b0011);
        i_ctrl.set_cke(1'b0);
        repeat (26) @(posedge clock);
        ev(4, 4'b0100);
        ev(14, 4'b0000);
        i_ctrl.set_cke(1'b1);
        repeat (16) @(posedge clock);
        bus(1'b1, 4'h0, 32'h1, 4'hf);
        rd(4'h0, 32'h1);
        ev(4, 4'b0001);
        i_ctrl.set_cke(1'b0);
        repeat (6) @(posedge clock);
        pulse(7, 3'b001);
        ev(4, 4'b0000);
        i_ctrl.set_cke(1'b1);
        repeat (8) @(posedge clock);
        final_report();
    end
endmodule
